/* verilog/pts_timer.sv */
/*
 * Period timer with prescaler, postscaler, external gate/reset and APB registers.
 * Assumes APB master on pclk; ext_src_in and clk_src_in are asynchronous pins;
 * dbg_freeze comes from debug logic on pclk.
 */
// Local design decisions: the placing of the registers and the APB slave port.
//
// Behaviour
// R1: three modes: free-running period, one-shot, monostable, with start/stop/reset options.
// R2: count increments on each rising prescaled timer clock.
// R3: count equal to period feeds postscaler and clears count next tick.
// R4: gated modes hold the count while gate inactive, resume from held value.
// R5: reset modes clear the count on selected source level or edge.
// R6: count and period readable and writable; reset gives count zero, period all ones.
// R7: prescaler and postscaler clear on count write, control write, reset, external reset.
// R8: control write leaves the count unchanged.
// R9: free-running: compare every tick; match returns count to zero, bumps postscaler.
// R10: postscaler equal to select gives one-cycle pulse and clears postscaler.
// R11: one-shot: first match clears run enable and stops until re-enabled.
// R12: one-shot postscale values above zero have no useful effect.
// R13: monostable stops at match, keeps run enable, restarts on external reset.
// R14: external trigger edges must be at least six timer clocks apart.
// R15: external trigger levels must last at least three timer clocks.
// R16: debug freeze makes the timer ignore all external triggers.
// R17: mode field in halt register; reset source chosen by separate select register.
// R18: prescale ratio and clock source are configurable, encodings parameterised.
// R19: count value driven out continuously to other peripherals.
`include "pts_consts.svh"

module pts_timer
    import pts_pkg::*;
#(
    parameter int RST_N = 8,
    parameter int CLK_N = 3,
    parameter int PSC_W = 7
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic [RST_N-1:0]      ext_src_in,
    input  wire logic [CLK_N-1:0]      clk_src_in,
    input  wire logic                  dbg_freeze,
    output logic      [`PTS_CNT_W-1:0] timer_count_out,
    output logic                       postscaled_pulse,
    output logic                       period_match,
    output logic                       irq
);

    logic [`PTS_CNT_W-1:0]   timer_count;
    logic [`PTS_CNT_W-1:0]   period_value;
    pts_ctl_t                timer_control_reg;
    pts_mode_t               halt_control_reg;
    logic [`PTS_RSEL_W-1:0]  reset_source_select;
    logic [`PTS_CSEL_W-1:0]  clock_source_select;
    logic [`PTS_EVT_W-1:0]   int_status;
    logic [`PTS_EVT_W-1:0]   int_mask;
    logic [`PTS_POST_W-1:0]  post_cnt;
    pts_state_t              state;
    pts_state_t              next_state;
    logic [RST_N+CLK_N-1:0]  sync_q;
    logic [CLK_N-1:0]        clk_prev;
    logic [CLK_N-1:0]        clk_edge;
    logic                    ext_q;
    logic                    ext_prev;
    logic                    ext_sel;
    logic                    src_tick;
    logic                    tick;
    logic                    access;
    logic                    hit;
    logic [31:0]             next_rdata;
    logic                    wr_count;
    logic                    wr_period;
    logic                    wr_ctrl;
    logic                    wr_status;
    logic                    trig_ok;
    logic                    edge_r;
    logic                    edge_f;
    logic                    rst_evt;
    logic                    lvl_rst;
    logic                    gate_ok;
    logic                    psc_clear;
    logic                    match;
    logic                    cnt_en;
    logic                    match_tick;
    logic                    post_hit;
    logic                    is_oneshot;
    logic                    is_mono;
    pts_evt_t                evt;

    // APB slave: zero wait states, read data captured in the setup cycle
    assign access    = psel & penable;
    assign pready    = 1'h1;
    assign pslverr   = access & ~hit;
    assign wr_count  = access & pwrite & (paddr == `PTS_OFF_COUNT);
    assign wr_period = access & pwrite & (paddr == `PTS_OFF_PERIOD);
    assign wr_ctrl   = access & pwrite & (paddr == `PTS_OFF_CTRL);
    assign wr_status = access & pwrite & (paddr == `PTS_OFF_STATUS);

    always_comb begin
        hit        = 1'h1;
        next_rdata = 32'h0000_0000;
        case (paddr)
            `PTS_OFF_COUNT:  next_rdata[`PTS_CNT_W-1:0]  = timer_count;      // see R6
            `PTS_OFF_PERIOD: next_rdata[`PTS_CNT_W-1:0]  = period_value;     // see R6
            `PTS_OFF_CTRL:   next_rdata[7:0]             = timer_control_reg;
            `PTS_OFF_HALT:   next_rdata[`PTS_MODE_W-1:0] = halt_control_reg;
            `PTS_OFF_RSTSEL: next_rdata[`PTS_RSEL_W-1:0] = reset_source_select;
            `PTS_OFF_CLKSEL: next_rdata[`PTS_CSEL_W-1:0] = clock_source_select;
            `PTS_OFF_STATUS: next_rdata[`PTS_EVT_W-1:0]  = int_status;
            `PTS_OFF_MASK:   next_rdata[`PTS_EVT_W-1:0]  = int_mask;
            default:         hit = 1'h0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel & ~penable & ~pwrite) begin
            prdata <= next_rdata;
        end
    end

    // configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_value        <= `PTS_RST_PERIOD;    // see R6
            halt_control_reg    <= pts_mode_t'(`PTS_RST_MODE);
            reset_source_select <= `PTS_RST_RSEL;
            clock_source_select <= `PTS_RST_CSEL;
            int_mask            <= `PTS_RST_EVT;
        end else if (access & pwrite) begin
            case (paddr)
                `PTS_OFF_PERIOD: period_value        <= pwdata[`PTS_CNT_W-1:0];
                `PTS_OFF_HALT:   halt_control_reg    <= pts_mode_t'(pwdata[`PTS_MODE_W-1:0]); // see R17
                `PTS_OFF_RSTSEL: reset_source_select <= pwdata[`PTS_RSEL_W-1:0];              // see R17
                `PTS_OFF_CLKSEL: clock_source_select <= pwdata[`PTS_CSEL_W-1:0];              // see R18
                `PTS_OFF_MASK:   int_mask            <= pwdata[`PTS_EVT_W-1:0];
                default: ;
            endcase
        end
    end

    // control register; one-shot match drops run enable unless software writes it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_control_reg <= pts_ctl_t'(`PTS_RST_CTRL);
        end else if (wr_ctrl) begin
            timer_control_reg <= pts_ctl_t'(pwdata[7:0]);
        end else if (is_oneshot & match_tick) begin
            timer_control_reg.run_enable <= 1'h0;           // see R11
        end
    end

    // external pins: synchronise, pick, freeze the selected gate/reset pin under debug
    pts_sync #(
        .W(RST_N + CLK_N)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({clk_src_in, ext_src_in}),
        .q       (sync_q)
    );

    assign ext_sel  = (int'(reset_source_select) < RST_N) ? sync_q[reset_source_select] : 1'h0;
    assign clk_edge = sync_q[RST_N +: CLK_N] & ~clk_prev;
    assign trig_ok  = ~dbg_freeze;                          // see R16

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_q    <= 1'h0;
            ext_prev <= 1'h0;
            clk_prev <= '0;
        end else begin
            // held while frozen, so a pin change made during freeze shows as an edge one cycle after thaw
            ext_q    <= dbg_freeze ? ext_q : ext_sel;       // see R16
            ext_prev <= ext_q;
            clk_prev <= sync_q[RST_N +: CLK_N];
        end
    end

    // clock source: pclk itself, or rising edges of a pin
    always_comb begin
        src_tick = 1'h1;                                    // see R18
        if (clock_source_select != `PTS_CLKSEL_PCLK) begin
            src_tick = 1'h0;
            for (int i = 0; i < CLK_N; i++) begin
                if (int'(clock_source_select) == i + 1) begin
                    src_tick = clk_edge[i];
                end
            end
        end
    end

    // mode decode
    assign is_oneshot = (halt_control_reg == PTS_M_ONESHOT);   // see R1
    assign is_mono    = (halt_control_reg == PTS_M_MONO_RISE) | (halt_control_reg == PTS_M_MONO_FALL) |
                        (halt_control_reg == PTS_M_MONO_ANY);
    assign edge_r     = ext_q & ~ext_prev;
    assign edge_f     = ~ext_q & ext_prev;

    always_comb begin
        rst_evt = 1'h0;
        lvl_rst = 1'h0;
        gate_ok = 1'h1;
        case (halt_control_reg)
            PTS_M_GATE_HI:   gate_ok = ext_q;                       // see R4
            PTS_M_GATE_LO:   gate_ok = ~ext_q;                      // see R4
            PTS_M_RST_RISE,
            PTS_M_MONO_RISE: rst_evt = trig_ok & edge_r;            // see R5
            PTS_M_RST_FALL,
            PTS_M_MONO_FALL: rst_evt = trig_ok & edge_f;            // see R5
            PTS_M_RST_ANY,
            PTS_M_MONO_ANY:  rst_evt = trig_ok & (edge_r | edge_f); // see R5
            PTS_M_RST_LOW:   lvl_rst = trig_ok & ~ext_q;            // see R5
            PTS_M_RST_HIGH:  lvl_rst = trig_ok & ext_q;             // see R5
            default: ;
        endcase
    end

    assign psc_clear = wr_count | wr_ctrl | rst_evt | lvl_rst;      // see R7

    pts_prescaler #(
        .PSC_W(PSC_W),
        .SEL_W(`PTS_PSC_SEL_W)
    ) u_psc (
        .pclk     (pclk),
        .presetn  (presetn),
        .clear    (psc_clear),
        .src_tick (src_tick),
        .ratio    (timer_control_reg.prescale_ratio),
        .tick     (tick)
    );

    // run state
    always_comb begin
        next_state = state;
        case (state)
            PTS_ST_IDLE: if (timer_control_reg.run_enable) next_state = PTS_ST_RUN;
            PTS_ST_RUN: begin
                if (!timer_control_reg.run_enable) next_state = PTS_ST_IDLE;
                else if (is_oneshot & match_tick) next_state = PTS_ST_IDLE;    // see R11
                else if (is_mono & match_tick) next_state = PTS_ST_HOLD;       // see R13
            end
            PTS_ST_HOLD: begin
                if (!timer_control_reg.run_enable) next_state = PTS_ST_IDLE;
                else if (rst_evt | wr_ctrl) next_state = PTS_ST_RUN;           // see R13
            end
            default: next_state = PTS_ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= PTS_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // counter; a control write has no branch here // see R8
    assign match      = (timer_count == period_value);
    assign cnt_en     = (state == PTS_ST_RUN) & timer_control_reg.run_enable & tick & gate_ok &
                        ~rst_evt & ~lvl_rst & ~wr_count;                       // see R2, R4
    assign match_tick = cnt_en & match;                                        // see R3, R9
    assign post_hit   = match_tick & (post_cnt == timer_control_reg.postscale_select);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_count <= `PTS_RST_COUNT;                                     // see R6
        end else if (wr_count) begin
            timer_count <= pwdata[`PTS_CNT_W-1:0];                             // see R6
        end else if (rst_evt | lvl_rst) begin
            timer_count <= `PTS_RST_COUNT;                                     // see R5
        end else if (cnt_en) begin
            timer_count <= match ? `PTS_RST_COUNT : `PTS_CNT_W'(timer_count + 1'h1); // see R2, R9
        end
    end

    // postscaler; one-shot restarts pass through psc_clear, so only select 0 ever fires
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            post_cnt <= '0;
        end else if (psc_clear) begin
            post_cnt <= '0;                                                    // see R7, R12
        end else if (match_tick) begin
            post_cnt <= post_hit ? '0 : `PTS_POST_W'(post_cnt + 1'h1);         // see R9, R10
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            postscaled_pulse <= 1'h0;
            period_match     <= 1'h0;
        end else begin
            postscaled_pulse <= post_hit;                                      // see R10
            period_match     <= match_tick;                                    // see R3
        end
    end

    assign timer_count_out = timer_count;                                      // see R19

    // interrupts: sticky, write one to clear, a new event beats the clear
    assign evt.period_match = match_tick;
    assign evt.post_pulse   = post_hit;
    assign evt.ext_event    = rst_evt;
    assign evt.oneshot_done = is_oneshot & match_tick;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_status <= `PTS_RST_EVT;
        end else begin
            int_status <= (int_status & ~(wr_status ? pwdata[`PTS_EVT_W-1:0] : `PTS_RST_EVT)) | evt;
        end
    end

    assign irq = |(int_status & int_mask);

    // checks
    sequence s_oneshot_match;
        is_oneshot && match_tick && !wr_ctrl;
    endsequence

    sequence s_stopped;
        !timer_control_reg.run_enable && state == PTS_ST_IDLE;
    endsequence

    a_match_clears: assert property (@(posedge pclk) disable iff (!presetn) // see R3
        match_tick |=> timer_count == 8'h00)
        else $error("count not cleared after period match");

    a_count_step: assert property (@(posedge pclk) disable iff (!presetn) // see R2
        cnt_en && !match |=> timer_count == $past(timer_count) + 8'h01)
        else $error("count did not step by one");

    a_gate_hold: assert property (@(posedge pclk) disable iff (!presetn) // see R4
        !gate_ok && !wr_count && !rst_evt && !lvl_rst |=> $stable(timer_count))
        else $error("count moved while gate inactive");

    a_level_reset: assert property (@(posedge pclk) disable iff (!presetn) // see R5
        lvl_rst && !wr_count |=> timer_count == 8'h00)
        else $error("level reset did not clear count");

    a_ctrl_keeps: assert property (@(posedge pclk) disable iff (!presetn) // see R8
        wr_ctrl && !wr_count && !rst_evt && !lvl_rst |=> $stable(timer_count) && post_cnt == 4'h0)
        else $error("control write disturbed count or postscaler");

    a_post_pulse: assert property (@(posedge pclk) disable iff (!presetn) // see R10
        match_tick && post_cnt == timer_control_reg.postscale_select |=> postscaled_pulse && post_cnt == 4'h0)
        else $error("postscaled pulse missing");

    a_oneshot_stop: assert property (@(posedge pclk) disable iff (!presetn) // see R11
        s_oneshot_match |=> s_stopped ##1 (state == PTS_ST_IDLE || timer_control_reg.run_enable))
        else $error("one-shot did not stop at match");

    a_mono_hold: assert property (@(posedge pclk) disable iff (!presetn) // see R13
        is_mono && match_tick && !wr_ctrl && timer_control_reg.run_enable |=>
        timer_control_reg.run_enable && state == PTS_ST_HOLD)
        else $error("monostable did not hold with run enable kept");

    a_freeze_ignore: assert property (@(posedge pclk) disable iff (!presetn) // see R16
        dbg_freeze |-> !rst_evt && !lvl_rst ##1 !rst_evt)
        else $error("external trigger acted during debug freeze");

    a_status_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        int_status[0] && !(wr_status && pwdata[0]) |=> int_status[0])
        else $error("status bit lost without a clear");

endmodule : pts_timer

/* verilog/pts_consts.svh */
/*
 * Register offsets, reset values and field widths of the period timer.
 * Assumes inclusion by bare name from the package and the timer top.
 */
`ifndef PTS_CONSTS_SVH
`define PTS_CONSTS_SVH

`define PTS_OFF_COUNT   8'h00
`define PTS_OFF_PERIOD  8'h04
`define PTS_OFF_CTRL    8'h08
`define PTS_OFF_HALT    8'h0C
`define PTS_OFF_RSTSEL  8'h10
`define PTS_OFF_CLKSEL  8'h14
`define PTS_OFF_STATUS  8'h18
`define PTS_OFF_MASK    8'h1C

`define PTS_RST_COUNT   8'h00
`define PTS_RST_PERIOD  8'hFF
`define PTS_RST_CTRL    8'h00
`define PTS_RST_MODE    4'h0
`define PTS_RST_RSEL    3'h0
`define PTS_RST_CSEL    2'h0
`define PTS_RST_EVT     4'h0

`define PTS_CLKSEL_PCLK 2'h0

`define PTS_CNT_W       8
`define PTS_POST_W      4
`define PTS_PSC_SEL_W   3
`define PTS_MODE_W      4
`define PTS_RSEL_W      3
`define PTS_CSEL_W      2
`define PTS_EVT_W       4

`endif

/* verilog/pts_pkg.sv */
/*
 * Types shared by the period timer: control layout, modes, states, events.
 * Assumes pts_consts.svh is on the include path.
 */
`include "pts_consts.svh"

package pts_pkg;

    typedef struct packed {
        logic                        run_enable;
        logic [`PTS_PSC_SEL_W-1:0]   prescale_ratio;
        logic [`PTS_POST_W-1:0]      postscale_select;
    } pts_ctl_t;

    typedef enum logic [`PTS_MODE_W-1:0] {
        PTS_M_FREE      = 4'h0,
        PTS_M_GATE_HI   = 4'h1,
        PTS_M_GATE_LO   = 4'h2,
        PTS_M_RST_RISE  = 4'h3,
        PTS_M_RST_FALL  = 4'h4,
        PTS_M_RST_ANY   = 4'h5,
        PTS_M_RST_LOW   = 4'h6,
        PTS_M_RST_HIGH  = 4'h7,
        PTS_M_ONESHOT   = 4'h8,
        PTS_M_MONO_RISE = 4'h9,
        PTS_M_MONO_FALL = 4'hA,
        PTS_M_MONO_ANY  = 4'hB
    } pts_mode_t;

    typedef enum logic [1:0] {
        PTS_ST_IDLE = 2'h0,
        PTS_ST_RUN  = 2'h1,
        PTS_ST_HOLD = 2'h3
    } pts_state_t;

    typedef struct packed {
        logic oneshot_done;
        logic ext_event;
        logic post_pulse;
        logic period_match;
    } pts_evt_t;

endpackage : pts_pkg

/* verilog/pts_sync.sv */
/*
 * Two-flop synchroniser for a bundle of independent levels.
 * Assumes each bit is a slow level; no bus coherency between bits.
 */
module pts_sync #(
    parameter int W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] stage1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1 <= '0;
            q      <= '0;
        end else begin
            stage1 <= d;
            q      <= stage1;
        end
    end

endmodule : pts_sync

/* verilog/pts_prescaler.sv */
/*
 * Power-of-two prescaler: passes one of every 2^ratio source ticks.
 * Assumes src_tick is a one-cycle pulse on pclk; clear has priority.
 */
module pts_prescaler #(
    parameter int PSC_W = 7,
    parameter int SEL_W = 3
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             clear,
    input  wire logic             src_tick,
    input  wire logic [SEL_W-1:0] ratio,
    output logic                  tick
);

    logic [PSC_W-1:0] cnt;
    logic [PSC_W-1:0] limit;

    assign limit = PSC_W'((PSC_W'(1) << ratio) - PSC_W'(1));
    // a tick landing on a clear is dropped so a restart begins a full period
    assign tick  = src_tick & ~clear & (cnt >= limit);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= '0;
        end else if (clear) begin
            cnt <= '0;
        end else if (src_tick) begin
            cnt <= (cnt >= limit) ? '0 : PSC_W'(cnt + PSC_W'(1));
        end
    end

endmodule : pts_prescaler

/* sim/pts_ext_src.sv */
/* model of the external gate/reset source pins of the timer.
   assumes the bench asks for pin levels on pclk; spacing is kept here. */
module pts_ext_src (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [7:0] req,
    output logic      [7:0] pins
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] gap;
    // a new level comes no sooner than seven clocks after the last change, so edges and levels never come too close
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins <= 8'h00;
            gap  <= 3'h0;
        end else if (gap != 3'h0) begin
            gap <= gap - 3'h1;
        end else if (req != pins) begin
            pins <= req;
            gap  <= 3'h6;
        end
    end
endmodule : pts_ext_src

/* sim/period_timer_with_postscaler_tb_top.sv */
/* self-checking bench of the period timer: apb tasks and one task per scenario.
   assumes pts_pkg and pts_consts.svh compiled ahead; gate/reset pins come from pts_ext_src, clock source pins are tied low. */
`include "pts_consts.svh"
module period_timer_with_postscaler_tb_top
    import pts_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  req = 8'h00;
    logic [7:0]  pins;
    logic        dbg_freeze = 1'b0;
    logic [7:0]  cnt;
    logic        pulse;
    logic        match;
    logic        irq;
    logic [31:0] rv;
    logic        ev;
    int          failures = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    always #2 pclk = ~pclk;
    pts_timer pts_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_src_in(pins), .clk_src_in(3'h0), .dbg_freeze(dbg_freeze),
        .timer_count_out(cnt), .postscaled_pulse(pulse), .period_match(match), .irq(irq));
    pts_ext_src pts_ext_src_inst (.pclk(pclk), .presetn(presetn), .req(req), .pins(pins));
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : wrap_up
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            wrap_up();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task automatic wm;
        int i;
        @(posedge pclk);
        for (i = 0; i < 400 && match !== 1'b1; i++) @(posedge pclk);
    endtask : wm
    task automatic t_reset;
        int i;
        for (i = 0; i < 8; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            chk(rv, (i == 1) ? 32'h0000_00FF : 32'h0);
        end
        $display("test reset values done");
    endtask : t_reset
    task automatic t_free;
        int n;
        int i;
        apb(1'b1, `PTS_OFF_PERIOD, 32'h3);
        apb(1'b1, `PTS_OFF_CTRL, 32'h82);
        wm();
        chk(cnt, 32'h0);
        n = 1;
        @(posedge pclk);
        while (match !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        chk(32'(n), 32'h4);
        for (i = 0; i < 100 && pulse !== 1'b1; i++) @(posedge pclk);
        n = 0;
        do begin
            @(posedge pclk);
            n += (match === 1'b1);
        end while (pulse !== 1'b1 && n < 10);
        chk(32'(n), 32'h3);
        @(posedge pclk);
        chk(pulse, 32'h0);
        apb(1'b1, `PTS_OFF_CTRL, 32'h90);
        wm();
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (match !== 1'b1 && n < 50);
        chk(32'(n), 32'h8);
        apb(1'b1, `PTS_OFF_CTRL, 32'h0);
        $display("test free running done");
    endtask : t_free
    task automatic t_regs;
        apb(1'b1, `PTS_OFF_COUNT, 32'h20);
        apb(1'b0, `PTS_OFF_COUNT, 32'h0);
        chk(rv, 32'h20);
        apb(1'b1, `PTS_OFF_CTRL, 32'h07);
        apb(1'b0, `PTS_OFF_COUNT, 32'h0);
        chk(rv, 32'h20);
        apb(1'b0, `PTS_OFF_PERIOD, 32'h0);
        chk(rv, 32'h3);
        $display("test register access done");
    endtask : t_regs
    task automatic t_oneshot;
        apb(1'b1, `PTS_OFF_HALT, 32'(PTS_M_ONESHOT));
        apb(1'b1, `PTS_OFF_COUNT, 32'h0);
        apb(1'b1, `PTS_OFF_CTRL, 32'h80);
        wm();
        repeat (6) @(posedge pclk);
        chk(cnt, 32'h0);
        apb(1'b0, `PTS_OFF_CTRL, 32'h0);
        chk(rv[7], 32'h0);
        apb(1'b1, `PTS_OFF_CTRL, 32'h80);
        wm();
        chk(match, 32'h1);
        $display("test one-shot done");
    endtask : t_oneshot
    task automatic t_mono;
        apb(1'b1, `PTS_OFF_PERIOD, 32'h40);
        apb(1'b1, `PTS_OFF_HALT, 32'(PTS_M_MONO_RISE));
        apb(1'b1, `PTS_OFF_CTRL, 32'h80);
        wm();
        repeat (8) @(posedge pclk);
        chk(cnt, 32'h0);
        apb(1'b0, `PTS_OFF_CTRL, 32'h0);
        chk(rv[7], 32'h1);
        dbg_freeze <= 1'b1;
        req <= 8'h01;
        repeat (12) @(posedge pclk);
        chk(cnt, 32'h0);
        req <= 8'h00;
        repeat (12) @(posedge pclk);
        dbg_freeze <= 1'b0;
        repeat (8) @(posedge pclk);
        chk(cnt, 32'h0);
        req <= 8'h01;
        repeat (12) @(posedge pclk);
        chk(32'(cnt != 8'h00), 32'h1);
        req <= 8'h00;
        $display("test monostable done");
    endtask : t_mono
    task automatic t_gate;
        logic [7:0] c;
        apb(1'b1, `PTS_OFF_HALT, 32'(PTS_M_GATE_HI));
        apb(1'b1, `PTS_OFF_COUNT, 32'h10);
        apb(1'b1, `PTS_OFF_CTRL, 32'h80);
        repeat (10) @(posedge pclk);
        chk(cnt, 32'h10);
        req <= 8'h01;
        repeat (12) @(posedge pclk);
        chk(32'(cnt > 8'h10), 32'h1);
        req <= 8'h00;
        repeat (8) @(posedge pclk);
        c = cnt;
        repeat (8) @(posedge pclk);
        chk(cnt, c);
        apb(1'b1, `PTS_OFF_HALT, 32'(PTS_M_RST_HIGH));
        req <= 8'h01;
        repeat (10) @(posedge pclk);
        chk(cnt, 32'h0);
        apb(1'b1, `PTS_OFF_HALT, 32'(PTS_M_GATE_LO));
        repeat (4) @(posedge pclk);
        chk(cnt, 32'h0);
        req <= 8'h00;
        repeat (12) @(posedge pclk);
        chk(32'(cnt != 8'h00), 32'h1);
        apb(1'b1, `PTS_OFF_CTRL, 32'h0);
        $display("test gate and reset done");
    endtask : t_gate
    task automatic t_irq;
        apb(1'b1, `PTS_OFF_HALT, 32'(PTS_M_FREE));
        apb(1'b1, `PTS_OFF_PERIOD, 32'h3);
        apb(1'b1, `PTS_OFF_STATUS, 32'hF);
        apb(1'b1, `PTS_OFF_CTRL, 32'h80);
        wm();
        apb(1'b1, `PTS_OFF_CTRL, 32'h0);
        chk(irq, 32'h0);
        apb(1'b1, `PTS_OFF_MASK, 32'h1);
        @(posedge pclk);
        chk(irq, 32'h1);
        apb(1'b1, `PTS_OFF_STATUS, 32'h1);
        apb(1'b0, `PTS_OFF_STATUS, 32'h0);
        chk(rv[0], 32'h0);
        chk(irq, 32'h0);
        apb(1'b1, 8'h20, 32'h5);
        chk(ev, 32'h1);
        $display("test interrupt and unmapped done");
    endtask : t_irq
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_free();
        t_regs();
        t_oneshot();
        t_mono();
        t_gate();
        t_irq();
        wrap_up();
    end
endmodule : period_timer_with_postscaler_tb_top
